// ==== core/fcsp_consts.vh ====
// constants for the flash card host strobe port
`ifndef FCSP_CONSTS_VH
`define FCSP_CONSTS_VH

// ------------------------------------------------------------
// interface modes
// ------------------------------------------------------------
`define FCSP_MODE_MEM     2'h0
`define FCSP_MODE_IO      2'h1
`define FCSP_MODE_ATA     2'h2

// ------------------------------------------------------------
// bus layout
// ------------------------------------------------------------
`define FCSP_DATA_W       16
`define FCSP_LOW_W        8
`define FCSP_ODD_LSB      8
`define FCSP_ADDR_W       11
`define FCSP_TF_ADDR_W    3
`define FCSP_TF_REGS      8
`define FCSP_CFG_REGS     4
`define FCSP_CFG_ADDR_W   2
`define FCSP_FIFO_DEPTH   8

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define FCSP_REG_RST      16'h0000
`define FCSP_STRB_RST     3'h7

`endif

// ==== core/fcsp_fifo.v ====
// fifo with valid and ready on both sides
`timescale 1ns/10ps

module fcsp_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    // clock and reset
    input  wire             clk,
    input  wire             arst_n,
    // fill side
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // drain side
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      count;

    wire push = in_valid && in_ready;
    wire pop  = out_valid && out_ready;

    assign in_ready  = (count != DEPTH[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data  = mem[rd_ptr];

    // storage has no reset, only pointers and count do
    always @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // pointers wrap at depth so depth need not be a power of two
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end

endmodule

// ==== core/fcsp_top.v ====
// card-side host strobe port: mode handling, strobes, task file, write fifo
// How it works
// - in memory mode the battery detect two pin is driven high at all times.
// - in io mode the audio pin is driven high, the card never makes sound.
// - in ata mode the drive active line is two-way, driven low when busy, else sensed.
// - in memory and io mode both card detect pins are low; host needs both low.
// - in ata mode the card detect pins carry no meaning and no logic reads them.
// - the 16-bit bus carries data, bit 0 is even byte lsb and bit 8 odd byte lsb.
// - in ata mode task file access uses the low 8 lines, data transfers all 16.
// - in memory mode the io read and io write strobes are ignored.
// - in io mode data is captured on the rising trailing edge of io write.
// - in io mode the card drives read data while the io read strobe is low.
// - in ata mode io write behaves as in io mode; io read has no config access and drives only the low lines for task file registers.
// - in memory mode write enable writes memory data and configuration registers.
// - in io mode write enable writes configuration only, io write does io registers.
// - in ata mode address bits 2..0 pick one of eight task file registers.
`timescale 1ns/10ps
`include "fcsp_consts.vh"

module fcsp_top #(
    parameter DW    = `FCSP_DATA_W,
    parameter AW    = `FCSP_ADDR_W,
    parameter DEPTH = `FCSP_FIFO_DEPTH
) (
    // clock and reset
    input  wire          CLK,
    input  wire          ARST_N,
    // mode selection, held static by the host
    input  wire [1:0]    MODE,
    // host address and strobes
    input  wire [AW-1:0] ADDR,
    input  wire          REG_SEL_N,
    input  wire          OUTPUT_ENABLE_N,
    input  wire          WRITE_ENABLE_N,
    input  wire          IO_READ_STROBE_N,
    input  wire          IO_WRITE_STROBE_N,
    // data bus, three-signal form
    input  wire [DW-1:0] DATA_IN,
    output reg  [DW-1:0] DATA_OUT,
    output reg  [DW-1:0] DATA_OE,
    // fixed-level status pins
    output reg           CARD_DETECT_ONE_N,
    output reg           CARD_DETECT_TWO_N,
    output reg           BATTERY_DETECT_TWO,
    output reg           AUDIO_OUT_N,
    // drive active / slave present, three-signal form
    input  wire          DRIVE_ACTIVE_SLAVE_PRESENT_N_IN,
    output reg           DRIVE_ACTIVE_SLAVE_PRESENT_N_OUT,
    output reg           DRIVE_ACTIVE_SLAVE_PRESENT_N_OE,
    input  wire          DRIVE_BUSY,
    output reg           OTHER_DRIVE_PRESENT,
    // write stream towards the flash controller
    output wire          WR_VALID,
    input  wire          WR_READY,
    output wire [DW-1:0] WR_DATA,
    output reg           WR_OVERRUN,
    // read data supplied by the flash controller
    input  wire [DW-1:0] RD_DATA
);

    // ------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------
    wire mode_mem = (MODE == `FCSP_MODE_MEM);
    wire mode_io  = (MODE == `FCSP_MODE_IO);
    wire mode_ata = (MODE == `FCSP_MODE_ATA) && !OUTPUT_ENABLE_N;

    // ------------------------------------------------------------
    // strobe synchronisers: io write, io read, write enable, output enable
    // ------------------------------------------------------------
    reg  [3:0] sync_a;
    reg  [3:0] sync_b;
    reg  [3:0] sync_c;
    wire [3:0] strb_raw = {OUTPUT_ENABLE_N, WRITE_ENABLE_N,
                           IO_READ_STROBE_N, IO_WRITE_STROBE_N};

    // first stage feeds only the second; third stage holds the old level for edges
    always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            sync_a <= 4'hf;
            sync_b <= 4'hf;
            sync_c <= 4'hf;
        end else begin
            sync_a <= strb_raw;
            sync_b <= sync_a;
            sync_c <= sync_b;
        end
    end

    wire io_write_strobe_n_rise = sync_b[0] && !sync_c[0];
    wire we_rise   = sync_b[2] && !sync_c[2];
    wire io_read_strobe_n_low  = !sync_b[1];
    wire oe_low    = !sync_b[3];

    // data and address are held stable by the host around the trailing edge,
    // but two cycles of synchroniser delay mean a slow host is assumed
    reg [DW-1:0] data_hold;
    reg [AW-1:0] addr_hold;
    reg          reg_hold;
    always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            data_hold <= `FCSP_REG_RST;
            addr_hold <= {AW{1'b0}};
            reg_hold  <= 1'b1;
        end else if (!sync_b[0] || !sync_b[2]) begin
            data_hold <= DATA_IN;
            addr_hold <= ADDR;
            reg_hold  <= REG_SEL_N;
        end
    end

    // ------------------------------------------------------------
    // write classification
    // ------------------------------------------------------------
    // io strobes act in io and ata mode only; memory mode drops them
    wire io_active = mode_io || mode_ata;
    wire io_wr     = io_active && io_write_strobe_n_rise;
    // write enable: memory mode any target, io mode config only, ata never
    wire we_ok     = (mode_mem || (mode_io && !reg_hold)) && !mode_ata;
    wire cfg_wr    = we_rise && we_ok && !reg_hold;
    wire mem_wr    = we_rise && mode_mem && reg_hold;
    // in ata mode address 0 is the 16-bit data port, the rest are byte registers
    wire [`FCSP_TF_ADDR_W-1:0] tf_idx = addr_hold[`FCSP_TF_ADDR_W-1:0];
    wire data_port = (tf_idx == 3'h0);
    wire tf_wr     = io_wr && !data_port;
    wire stream_wr = (io_wr && data_port) || mem_wr;

    // ------------------------------------------------------------
    // task file and configuration registers
    // ------------------------------------------------------------
    reg [`FCSP_LOW_W-1:0] task_file [0:`FCSP_TF_REGS-1];
    reg [DW-1:0]          cfg_reg   [0:`FCSP_CFG_REGS-1];
    integer i;

    // task file writes only store the even byte on the low lines; config writes store all 16
    always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            for (i = 0; i < `FCSP_TF_REGS; i = i + 1) begin
                task_file[i] <= 8'h00;
            end
            for (i = 0; i < `FCSP_CFG_REGS; i = i + 1) begin
                cfg_reg[i] <= `FCSP_REG_RST;
            end
        end else begin
            if (tf_wr) begin
                task_file[tf_idx] <= data_hold[`FCSP_LOW_W-1:0];
            end
            if (cfg_wr) begin
                cfg_reg[addr_hold[`FCSP_CFG_ADDR_W-1:0]] <= data_hold;
            end
        end
    end

    // ------------------------------------------------------------
    // write stream fifo
    // ------------------------------------------------------------
    wire fifo_in_ready;
    fcsp_fifo #(
        .WIDTH (DW),
        .DEPTH (DEPTH),
        .AW    (3)
    ) u_fifo (
        .clk       (CLK),
        .arst_n    (ARST_N),
        .in_valid  (stream_wr),
        .in_ready  (fifo_in_ready),
        .in_data   (data_hold),
        .out_valid (WR_VALID),
        .out_ready (WR_READY),
        .out_data  (WR_DATA)
    );

    // a strobe cannot be held off, so a full fifo is flagged sticky until reset
    always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            WR_OVERRUN <= 1'b0;
        end else if (stream_wr && !fifo_in_ready) begin
            WR_OVERRUN <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    reg [DW-1:0] next_rd_word;
    reg          next_drive;
    always @* begin
        next_rd_word = RD_DATA;
        next_drive   = 1'b0;
        if (io_active && io_read_strobe_n_low) begin
            next_drive = 1'b1;
            if (!REG_SEL_N && mode_io) begin
                next_rd_word = cfg_reg[ADDR[`FCSP_CFG_ADDR_W-1:0]];
            end else if (ADDR[`FCSP_TF_ADDR_W-1:0] != 3'h0) begin
                // io writes land in the task file in io mode too, so reads must see them
                next_rd_word = {8'h00, task_file[ADDR[`FCSP_TF_ADDR_W-1:0]]};
            end
        end else if (!io_active && oe_low) begin
            next_drive = 1'b1;
            if (!REG_SEL_N) begin
                next_rd_word = cfg_reg[ADDR[`FCSP_CFG_ADDR_W-1:0]];
            end
        end
    end

    // in ata task file reads only the low lines are driven
    always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            DATA_OUT <= `FCSP_REG_RST;
            DATA_OE  <= {DW{1'b0}};
        end else begin
            DATA_OUT <= next_rd_word;
            if (!next_drive) begin
                DATA_OE <= {DW{1'b0}};
            end else if (mode_ata && ADDR[`FCSP_TF_ADDR_W-1:0] != 3'h0) begin
                DATA_OE <= 16'h00ff;
            end else begin
                DATA_OE <= {DW{1'b1}};
            end
        end
    end

    // ------------------------------------------------------------
    // fixed-level pins and drive active line
    // ------------------------------------------------------------
    // ata mode drives card detect high; nothing inside reads them
    always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            CARD_DETECT_ONE_N                <= 1'b0;
            CARD_DETECT_TWO_N                <= 1'b0;
            BATTERY_DETECT_TWO               <= 1'b1;
            AUDIO_OUT_N                      <= 1'b1;
            DRIVE_ACTIVE_SLAVE_PRESENT_N_OUT <= 1'b0;
            DRIVE_ACTIVE_SLAVE_PRESENT_N_OE  <= 1'b0;
            OTHER_DRIVE_PRESENT              <= 1'b0;
        end else begin
            CARD_DETECT_ONE_N  <= mode_ata;
            CARD_DETECT_TWO_N  <= mode_ata;
            BATTERY_DETECT_TWO <= 1'b1;
            AUDIO_OUT_N        <= 1'b1;
            DRIVE_ACTIVE_SLAVE_PRESENT_N_OUT <= 1'b0;
            // open-drain style: pull low while busy, else listen for the other drive
            DRIVE_ACTIVE_SLAVE_PRESENT_N_OE  <= mode_ata && DRIVE_BUSY;
            OTHER_DRIVE_PRESENT <= mode_ata && !DRIVE_BUSY
                                   && !DRIVE_ACTIVE_SLAVE_PRESENT_N_IN;
        end
    end

endmodule

// ==== dv/fcsp_chk.sv ====
// concurrent checks on the ports of the flash card host strobe port
`timescale 1ns/10ps
`include "fcsp_consts.vh"
module fcsp_chk #(
    parameter DW    = 16,
    parameter AW    = 11,
    parameter DEPTH = 8
) (
    // clock and reset
    input wire          CLK,
    input wire          ARST_N,
    // host side
    input wire [1:0]    MODE,
    input wire [AW-1:0] ADDR,
    input wire          REG_SEL_N,
    input wire          WRITE_ENABLE_N,
    input wire          IO_READ_STROBE_N,
    input wire          IO_WRITE_STROBE_N,
    input wire [DW-1:0] DATA_OE,
    // status pins
    input wire          CARD_DETECT_ONE_N,
    input wire          CARD_DETECT_TWO_N,
    input wire          BATTERY_DETECT_TWO,
    input wire          AUDIO_OUT_N,
    input wire          DRIVE_ACTIVE_SLAVE_PRESENT_N_OUT,
    input wire          DRIVE_ACTIVE_SLAVE_PRESENT_N_OE,
    input wire          DRIVE_BUSY,
    // write stream
    input wire          WR_VALID
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    wire ata = (MODE == `FCSP_MODE_ATA);
    wire mem = (MODE == `FCSP_MODE_MEM);
    // ----------------------------------------
    // strobe steps
    // ----------------------------------------
    sequence s_wr_end;
        $rose(IO_WRITE_STROBE_N) && !mem && ADDR == '0 && REG_SEL_N && !WR_VALID;
    endsequence
    sequence s_rd_go;
        $fell(IO_READ_STROBE_N) && !mem && REG_SEL_N;
    endsequence
    AST_BVD_HIGH: assert property (mem |-> BATTERY_DETECT_TWO)
        else $error("battery detect two low");
    AST_AUDIO_HIGH: assert property (MODE == `FCSP_MODE_IO |-> AUDIO_OUT_N)
        else $error("audio line low");
    AST_CD_LOW: assert property (!ata |-> !CARD_DETECT_ONE_N && !CARD_DETECT_TWO_N)
        else $error("card detect not low");
    AST_DRIVE_ACTIVE_SLAVE_PRESENT_N_DRIVE: assert property (ata && DRIVE_BUSY |=>
        DRIVE_ACTIVE_SLAVE_PRESENT_N_OE && !DRIVE_ACTIVE_SLAVE_PRESENT_N_OUT)
        else $error("activity line not driven low");
    AST_WR_TRAIL: assert property (s_wr_end |-> ##[2:5] WR_VALID)
        else $error("io write word not pushed");
    AST_NO_EARLY: assert property (MODE == `FCSP_MODE_IO && !IO_WRITE_STROBE_N
        && WRITE_ENABLE_N && !WR_VALID |=> !WR_VALID)
        else $error("word pushed before trailing edge");
    AST_IO_IGN: assert property (mem && $rose(IO_WRITE_STROBE_N) && !WR_VALID
        |=> !WR_VALID [*6])
        else $error("io write acted on in memory mode");
    AST_RD_ON: assert property (s_rd_go |-> ##[2:4] DATA_OE != '0)
        else $error("read data not driven");
    AST_TF_LOW: assert property (ata && DATA_OE != '0 && ADDR[2:0] != 3'h0
        |-> DATA_OE == 16'h00ff)
        else $error("task file read not on low lines");
endmodule

// ==== dv/fcsp_host.sv ====
// host socket model making strobes, address and data for the card
`timescale 1ns/10ps
`include "fcsp_consts.vh"
module fcsp_host (
    // clock and mode
    input  wire        clk,
    input  wire [1:0]  mode,
    // address and strobes
    output reg  [10:0] addr = 11'h000,
    output reg         reg_sel_n = 1'b1,
    output wire        oe_n,
    output reg         we_n = 1'b1,
    output reg         io_read_strobe_n_n = 1'b1,
    output reg         io_write_strobe_n_n = 1'b1,
    // data bus
    output wire [15:0] data_in,
    input  wire [15:0] data_out,
    input  wire [15:0] data_oe
);
    reg        drv = 1'b0;
    reg        oe_idle = 1'b1;
    reg [15:0] hdata = 16'h0000;
    reg [15:0] last = 16'h0000;
    wire       ata = (mode == `FCSP_MODE_ATA);
    // output enable grounded selects disk mode, otherwise it is a read strobe
    assign oe_n = !ata && oe_idle;
    // undriven bits show the inverse of the last word, never a stale copy
    assign data_in = drv ? hdata : ((data_oe & data_out) | (~data_oe & ~last));
    // one cycle: kind 0 io write, 1 io read, 2 write enable, 3 output enable; 5 low, 10 high
    task acc(input [1:0] kind, input [10:0] a, input rs, input [15:0] d,
             output [15:0] q, output [15:0] qoe);
        begin
            @(negedge clk);
            addr = ata ? {8'h00, a[2:0]} : a;
            reg_sel_n = rs;
            hdata = d;
            drv = !kind[0];
            repeat (5) begin
                @(negedge clk);
                io_write_strobe_n_n = (kind != 2'd0);
                io_read_strobe_n_n = (kind != 2'd1);
                we_n = (kind != 2'd2) || ata;
                oe_idle = (kind != 2'd3);
            end
            q = data_in;
            qoe = data_oe;
            @(negedge clk);
            {io_write_strobe_n_n, io_read_strobe_n_n, we_n, oe_idle} = 4'hf;
            repeat (2) @(negedge clk);
            last = data_in;
            drv = 1'b0;
            repeat (6) @(negedge clk);
        end
    endtask
endmodule

// ==== dv/fcsp_tb.sv ====
// self-checking bench for the flash card host strobe port
`timescale 1ns/10ps
`include "fcsp_consts.vh"
module tb_top;
    reg         clk = 1'b0;
    reg         arst_n = 1'b0;
    reg [1:0]   mode = `FCSP_MODE_IO;
    reg         busy = 1'b0;
    reg         other_low = 1'b0;
    reg         wr_ready = 1'b0;
    reg [15:0]  rd_data = 16'h0000;
    reg [31:0]  seed = 32'h594bfc99;
    reg [15:0]  q, qoe, w;
    reg [15:0]  expq [$];
    integer     error_cnt = 0;
    integer     cmp_count = 0;
    integer     cyc = 0;
    integer     i, k;
    reg [10:0]  ra;
    wire [10:0] addr;
    wire [15:0] din, dout, doe, wr_data;
    wire        rs_n, oe_n, we_n, rd_n, wr_n, cd1, cd2, bvd, aud;
    wire        d_out, d_oe, odp, wr_valid, wr_ovr;
    // shared activity line with a pull-up, either drive may pull it low
    wire        drive_active_slave_present_n = ~((d_oe & ~d_out) | other_low);

    always #25 clk = ~clk;
    fcsp_host host (.clk(clk), .mode(mode), .addr(addr), .reg_sel_n(rs_n), .oe_n(oe_n),
        .we_n(we_n), .io_read_strobe_n_n(rd_n), .io_write_strobe_n_n(wr_n), .data_in(din), .data_out(dout),
        .data_oe(doe));
    fcsp_top uut (.CLK(clk), .ARST_N(arst_n), .MODE(mode), .ADDR(addr), .REG_SEL_N(rs_n),
        .OUTPUT_ENABLE_N(oe_n), .WRITE_ENABLE_N(we_n), .IO_READ_STROBE_N(rd_n),
        .IO_WRITE_STROBE_N(wr_n), .DATA_IN(din), .DATA_OUT(dout), .DATA_OE(doe),
        .CARD_DETECT_ONE_N(cd1), .CARD_DETECT_TWO_N(cd2), .BATTERY_DETECT_TWO(bvd),
        .AUDIO_OUT_N(aud), .DRIVE_ACTIVE_SLAVE_PRESENT_N_IN(drive_active_slave_present_n),
        .DRIVE_ACTIVE_SLAVE_PRESENT_N_OUT(d_out), .DRIVE_ACTIVE_SLAVE_PRESENT_N_OE(d_oe),
        .DRIVE_BUSY(busy), .OTHER_DRIVE_PRESENT(odp), .WR_VALID(wr_valid),
        .WR_READY(wr_ready), .WR_DATA(wr_data), .WR_OVERRUN(wr_ovr), .RD_DATA(rd_data));

    task chk(input string nm, input [15:0] e, input [15:0] g);
        begin
            cmp_count = cmp_count + 1;
            if (g !== e) begin
                error_cnt = error_cnt + 1;
                $display("Error %s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    // a mode is only changed under reset, so every phase starts clean
    task set_mode(input [1:0] m);
        begin
            arst_n = 1'b0;
            mode = m;
            repeat (3) @(negedge clk);
            arst_n = 1'b1;
            @(negedge clk);
            chk("card_detect", (m == `FCSP_MODE_ATA) ? 16'h0003 : 16'h0000, {14'h0, cd1, cd2});
            chk("bvd_audio", 16'h0003, {14'h0, bvd, aud});
        end
    endtask
    // stall far side while filling, then empty the fifo against the queue
    task drain;
        begin
            for (i = 0; i < 40 && expq.size() > 0; i = i + 1) begin
                @(negedge clk);
                if (wr_valid === 1'b1) chk("wr_data", expq.pop_front(), wr_data);
                wr_ready = 1'b1;
            end
            @(negedge clk);
            wr_ready = 1'b0;
            chk("words_left", 16'h0000, expq.size());
            chk("wr_valid", 16'h0000, {15'h0, wr_valid});
        end
    endtask
    function [15:0] exp_oe(input [2:0] a);
        exp_oe = (a != 3'h0) ? 16'h00ff : 16'hffff;
    endfunction
    task conclude;
        begin
            $display("comparisons %0d errors %0d", cmp_count, error_cnt);
            if (error_cnt == 0 && cmp_count > 0) $display("*** PASS ***");
            else $display("*** FAIL ***");
            $finish;
        end
    endtask

    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 5000) begin
            error_cnt = error_cnt + 1;
            conclude;
        end
    end
    initial begin
        // io mode: fill past depth with the far side stalled
        set_mode(`FCSP_MODE_IO);
        for (k = 0; k < 9; k = k + 1) begin
            w = $random(seed);
            if (k < 8) expq.push_back(w);
            chk("overrun", 16'h0000, {15'h0, wr_ovr});
            host.acc(2'd0, 11'h000, 1'b1, w, q, qoe);
        end
        chk("overrun", 16'h0001, {15'h0, wr_ovr});
        drain;
        host.acc(2'd2, 11'h000, 1'b1, $random(seed), q, qoe);
        chk("we_in_io", 16'h0000, {15'h0, wr_valid});
        w = $random(seed);
        host.acc(2'd0, 11'h003, 1'b1, w, q, qoe);
        host.acc(2'd1, 11'h003, 1'b1, 16'h0000, q, qoe);
        chk("io_read", {8'h00, w[7:0]}, q & 16'h00ff);
        // config space: write enable with register select low, read back by io read
        w = $random(seed);
        host.acc(2'd2, 11'h001, 1'b0, w, q, qoe);
        host.acc(2'd1, 11'h001, 1'b0, 16'h0000, q, qoe);
        chk("io_cfg_read", w, q);
        // memory mode: io strobes ignored, write enable pushes
        set_mode(`FCSP_MODE_MEM);
        host.acc(2'd0, 11'h000, 1'b1, $random(seed), q, qoe);
        chk("io_in_mem", 16'h0000, {15'h0, wr_valid});
        w = $random(seed);
        expq.push_back(w);
        host.acc(2'd2, 11'h000, 1'b1, w, q, qoe);
        drain;
        // config write by write enable, read by output enable; no fifo push
        w = $random(seed);
        host.acc(2'd2, 11'h002, 1'b0, w, q, qoe);
        host.acc(2'd3, 11'h002, 1'b0, 16'h0000, q, qoe);
        chk("mem_cfg_read", w, q);
        chk("cfg_no_push", 16'h0000, {15'h0, wr_valid});
        host.acc(2'd1, 11'h002, 1'b1, 16'h0000, q, qoe);
        chk("io_read_strobe_n_in_mem", 16'h0000, qoe);
        // disk mode: every task file byte, the data port both ways
        set_mode(`FCSP_MODE_ATA);
        for (k = 0; k < 8; k = k + 1) begin
            w = $random(seed);
            rd_data = $random(seed);
            if (k == 0) expq.push_back(w);
            // upper address bits random in ra but cleared by the host in disk mode; low three bits pick register k
            ra = $random(seed);
            ra[2:0] = k[2:0];
            host.acc(2'd0, ra, 1'b1, w, q, qoe);
            host.acc(2'd1, ra ^ 11'h7f8, 1'b1, 16'h0000, q, qoe);
            chk("ata_oe", exp_oe(k), qoe);
            chk("ata_read", (k == 0) ? rd_data : {8'h00, w[7:0]}, q & exp_oe(k));
        end
        drain;
        busy = 1'b1;
        repeat (3) @(negedge clk);
        chk("drive_active_slave_present_n_drive", 16'h0002, {13'h0, odp, d_oe, d_out});
        busy = 1'b0;
        other_low = 1'b1;
        repeat (4) @(negedge clk);
        chk("other_drive", 16'h0001, {15'h0, odp});
        conclude;
    end
endmodule

bind fcsp_top fcsp_chk #(.DW(DW), .AW(AW), .DEPTH(DEPTH)) chk (.CLK(CLK), .ARST_N(ARST_N),
    .MODE(MODE), .ADDR(ADDR), .REG_SEL_N(REG_SEL_N), .WRITE_ENABLE_N(WRITE_ENABLE_N),
    .IO_READ_STROBE_N(IO_READ_STROBE_N), .IO_WRITE_STROBE_N(IO_WRITE_STROBE_N),
    .DATA_OE(DATA_OE), .CARD_DETECT_ONE_N(CARD_DETECT_ONE_N),
    .CARD_DETECT_TWO_N(CARD_DETECT_TWO_N), .BATTERY_DETECT_TWO(BATTERY_DETECT_TWO),
    .AUDIO_OUT_N(AUDIO_OUT_N),
    .DRIVE_ACTIVE_SLAVE_PRESENT_N_OUT(DRIVE_ACTIVE_SLAVE_PRESENT_N_OUT),
    .DRIVE_ACTIVE_SLAVE_PRESENT_N_OE(DRIVE_ACTIVE_SLAVE_PRESENT_N_OE),
    .DRIVE_BUSY(DRIVE_BUSY), .WR_VALID(WR_VALID));
